/* File: hw/dsb_pkg.sv */
// Purpose : Shared constants for the delta-sigma bitstream output block
// Assumes : Analog input arrives as signed words in 10 uV steps
// Notes   : Levels are in the same 10 uV unit as the input words
package dsb_pkg;

   // ----------------------------------------------------------------------
   // Input scaling
   // ----------------------------------------------------------------------
   localparam int unsigned IN_W = 16;
   localparam int unsigned ACC_W = 32;

   // 250 mV linear full scale and 320 mV clip / feedback reference
   localparam logic signed [ACC_W-1:0] FULL_SCALE = 32'sh000061a8;
   localparam logic signed [ACC_W-1:0] CLIP_LEVEL = 32'sh00007d00;

   // ----------------------------------------------------------------------
   // Data buffer shape
   // ----------------------------------------------------------------------
   localparam int unsigned BUF_WIDTH = 1;
   localparam int unsigned BUF_DEPTH = 2;

   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic DATA_RST  = 1'b0;
   localparam logic MCLK_RST  = 1'b0;
   localparam logic BIT_RST   = 1'b0;

endpackage

/* File: hw/dsb_buf_if.sv */
// Purpose : Valid/ready carrier between the modulator and its bit buffer
// Assumes : Both sides run on the same clock
// Notes   : Words move when valid and ready are high together
`timescale 1ns/1ns
interface dsb_buf_if #(
   parameter int unsigned WIDTH = dsb_pkg::BUF_WIDTH
);
   logic             in_valid;
   logic             in_ready;
   logic [WIDTH-1:0] in_data;
   logic             out_valid;
   logic             out_ready;
   logic [WIDTH-1:0] out_data;

   modport buffer (
      input  in_valid, in_data, out_ready,
      output in_ready, out_valid, out_data
   );
   modport user (
      output in_valid, in_data, out_ready,
      input  in_ready, out_valid, out_data
   );
endinterface

/* File: hw/dsb_buf.sv */
// Purpose : Small FIFO holding modulator bits until the output edge
// Assumes : Asynchronous active-low reset, release synchronised in the top module
// Notes   : Full and empty are exact; a push into a full buffer is refused
`timescale 1ns/1ns
module dsb_buf #(
   parameter int unsigned WIDTH = dsb_pkg::BUF_WIDTH,
   parameter int unsigned DEPTH = dsb_pkg::BUF_DEPTH
) (
   input wire logic   clk,    // System clock
   input wire logic   rst_n,  // Synchronised reset, active low
   dsb_buf_if.buffer  bi      // Fill and drain handshakes
);
   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wr;
      logic [PW-1:0]               rd;
      logic [CW-1:0]               count;
   } dsb_buf_state_t;

   dsb_buf_state_t s;
   dsb_buf_state_t next_s;
   logic           push;
   logic           pop;

   assign bi.in_ready  = (s.count != CW'(DEPTH));
   assign bi.out_valid = (s.count != '0);
   assign bi.out_data  = s.mem[s.rd];
   assign push         = bi.in_valid & bi.in_ready;
   assign pop          = bi.out_valid & bi.out_ready;

   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wr] = bi.in_data;
         next_s.wr = (s.wr == PW'(DEPTH - 1)) ? '0 : s.wr + PW'(1);
      end
      if (pop) begin
         next_s.rd = (s.rd == PW'(DEPTH - 1)) ? '0 : s.rd + PW'(1);
      end
      next_s.count = s.count + CW'(push) - CW'(pop);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   AST_BUF_NO_OVERFLOW: assert property (
      @(posedge clk) disable iff (!rst_n)
      (s.count == CW'(DEPTH)) |-> !bi.in_ready ##1 (s.count <= CW'(DEPTH))
   ) else $error("buffer count passed its depth");

   AST_BUF_ORDER: assert property (
      @(posedge clk) disable iff (!rst_n)
      (push && s.count == '0 && !pop) |=> (bi.out_data == $past(bi.in_data))
   ) else $error("buffer head is not the first word pushed");

endmodule // dsb_buf

/* File: hw/dsb_modulator.sv */
// Purpose : Digital side of a second-order delta-sigma modulator; emits
//           one bit per cycle of the host supplied modulator clock
// Assumes : MOD_CLK_IN is synchronous to REF_CLK and much slower than it
// Notes   : Analog inputs are signed words in 10 uV steps
//
// Functional notes
// - One new output bit is produced per modulator clock cycle.
// - The serial output changes only on the falling modulator clock edge.
// - A zero differential input gives ideally half ones.
// - Positive full scale of 250 mV gives 89.06 percent ones.
// - Negative full scale gives 10.94 percent ones.
// - At or beyond +/-320 mV the output clips to all ones or all zeros.
// - Between 250 and 320 mV the density is non-linear.
// - The average of the output tracks the differential input.
// - Feedback follows the comparator decision on the next clock pulse.
// - One input sample and discharge happens per modulator clock period.
// - There are no modes or configuration inputs, only modulation.
`timescale 1ns/1ns
module dsb_modulator (
   input  wire logic                           REF_CLK,    // 125 MHz clock
   input  wire logic                           RESETN,     // Async reset
   input  wire logic                           MOD_CLK_IN, // Host bit clock
   input  wire logic signed [dsb_pkg::IN_W-1:0] POS_IN,    // Positive input
   input  wire logic signed [dsb_pkg::IN_W-1:0] NEG_IN,    // Negative input
   output      logic                           DATA_OUT    // Serial stream
);
   localparam int unsigned AW = dsb_pkg::ACC_W;

   // ----------------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------------
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic                 mclk_q;  // Last modulator clock level
      logic                 bit_q;   // Comparator decision driving the DAC
      logic signed [AW-1:0] int1;    // First integrator
      logic signed [AW-1:0] int2;    // Second integrator
      logic                 data;    // Pin register
   } dsb_state_t;

   dsb_state_t           s;
   dsb_state_t           next_s;
   logic                 rise;
   logic                 fall;
   logic signed [AW-1:0] diff;
   logic signed [AW-1:0] dac;
   logic signed [AW-1:0] step1;
   logic signed [AW-1:0] step2;
   logic                 clip_hi;
   logic                 clip_lo;
   logic                 decision;
   logic                 step;

   dsb_buf_if #(.WIDTH(dsb_pkg::BUF_WIDTH)) bi ();

   dsb_buf #(
      .WIDTH (dsb_pkg::BUF_WIDTH),
      .DEPTH (dsb_pkg::BUF_DEPTH)
   ) u_buf (
      .clk   (REF_CLK),
      .rst_n (rst_n),
      .bi    (bi)
   );

   // ----------------------------------------------------------------------
   // Edge detection and loop arithmetic
   // ----------------------------------------------------------------------
   // The clock is the host's own (pin sampled synchronously), not a local
   // divider, so bit timing follows the host exactly.
   assign rise = MOD_CLK_IN & ~s.mclk_q;
   assign fall = ~MOD_CLK_IN & s.mclk_q;

   assign diff    = AW'(POS_IN) - AW'(NEG_IN);
   assign clip_hi = (diff >= dsb_pkg::CLIP_LEVEL);
   assign clip_lo = (diff <= -dsb_pkg::CLIP_LEVEL);

   // DAC level comes from the previous decision, one pulse late
   assign dac = s.bit_q ? dsb_pkg::CLIP_LEVEL
                        : -dsb_pkg::CLIP_LEVEL;

   // Half gains keep the second-order loop stable out to full scale; with a
   // 320 mV DAC the density is 0.5 + diff / 640 mV.
   assign step1 = s.int1 + ((diff - dac) >>> 1);
   assign step2 = s.int2 + ((step1 - dac) >>> 1);

   always_comb begin
      if (clip_hi) begin
         decision = 1'b1;
      end else if (clip_lo) begin
         decision = 1'b0;
      end else begin
         decision = (s.int2 >= 0);
      end
   end

   // A full buffer stalls the loop instead of dropping a bit
   assign step        = rise & bi.in_ready;
   assign bi.in_valid = rise;
   assign bi.in_data  = decision;
   assign bi.out_ready = fall;

   always_comb begin
      next_s        = s;
      next_s.mclk_q = MOD_CLK_IN;
      if (step) begin
         next_s.bit_q = decision;
         if (!(clip_hi || clip_lo)) begin
            next_s.int1 = step1;
            next_s.int2 = step2;
         end
      end
      if (fall && bi.out_valid) begin
         next_s.data = bi.out_data;
      end
   end

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         s.mclk_q <= dsb_pkg::MCLK_RST;
         s.bit_q  <= dsb_pkg::BIT_RST;
         s.int1   <= '0;
         s.int2   <= '0;
         s.data   <= dsb_pkg::DATA_RST;
      end else begin
         s <= next_s;
      end
   end

   assign DATA_OUT = s.data;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!rst_n);

   sequence s_take_bit;
      step && bi.out_valid == 1'b0;
   endsequence

   sequence s_next_fall;
      (!fall) [*1] ##[0:100] (fall && bi.out_valid);
   endsequence

   AST_FALL_ONLY: assert property (
      $changed(DATA_OUT) |-> $past(fall)
   ) else $error("output changed away from a falling edge");

   AST_CLIP_HIGH: assert property (
      (step && clip_hi) |=> s.bit_q
   ) else $error("clip high did not force a one");

   AST_CLIP_LOW: assert property (
      (step && clip_lo) |=> !s.bit_q
   ) else $error("clip low did not force a zero");

   AST_ONE_PUSH_PER_RISE: assert property (
      bi.in_valid |-> rise ##1 !bi.in_valid
   ) else $error("more than one bit offered per clock cycle");

   AST_DAC_FOLLOWS: assert property (
      step |=> (dac == ($past(decision) ? dsb_pkg::CLIP_LEVEL
                                        : -dsb_pkg::CLIP_LEVEL))
   ) else $error("feedback did not follow the last decision");

   AST_STEP_ONCE: assert property (
      step |=> !step [*2]
   ) else $error("two samples taken in one modulator period");

   AST_LINEAR_BOUND: assert property (
      (diff <= dsb_pkg::FULL_SCALE && diff >= -dsb_pkg::FULL_SCALE)
      |-> (s.int1 < 4 * dsb_pkg::CLIP_LEVEL &&
           s.int1 > -4 * dsb_pkg::CLIP_LEVEL)
   ) else $error("first integrator left its bound in the linear range");

   AST_BIT_REACHES_PIN: assert property (
      s_take_bit ##1 s_next_fall |=> (DATA_OUT == $past(bi.out_data))
   ) else $error("bit taken at a rise did not reach the pin");

   AST_ZERO_TOGGLES: assert property (
      (step && diff == 0 && s.int1 == 0 && s.int2 == 0 && !s.bit_q)
      |=> s.bit_q
   ) else $error("zero input from rest did not answer with a one");

endmodule // dsb_modulator

/* File: testbench/dsb_host_model.sv */
// Purpose : Host side model that supplies the bit clock and counts ones
// Assumes : Called from the bench through run_bits
// Notes   : The bit clock stands low between frames
`timescale 1ns/1ns
module dsb_host_model (
   input  wire logic clk,     // Bench reference clock
   input  wire logic data_in, // Serial stream from the device
   output logic      mod_clk, // Modulator clock to the device
   output int        ones,    // Ones counted in the last window
   output logic      done     // One-cycle pulse after a reported window
);
   initial begin
      mod_clk = 1'b0;
      ones = 0;
      done = 1'b0;
   end

   // ----------------------------------------------------------------------
   // Bit clock and sampler
   // ----------------------------------------------------------------------
   // Phases of 3 to 12 reference cycles keep the period in 48..192 ns
   task automatic run_bits(input int n, input int half, input bit report);
      int cnt;
      cnt = 0;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         mod_clk <= 1'b1;
         cnt += (data_in === 1'b1);
         repeat (half) @(posedge clk);
         mod_clk <= 1'b0;
         repeat (half - 1) @(posedge clk);
      end
      if (report) begin
         @(posedge clk);
         ones <= cnt;
         done <= 1'b1;
         @(posedge clk);
         done <= 1'b0;
      end
   endtask
endmodule // dsb_host_model

/* File: testbench/delta_sigma_bitstream_output_tb.sv */
// Purpose : Self-checking bench for the delta-sigma bitstream output
// Assumes : Windows of 256 bits, 10 uV per input step
// Notes   : Density is judged after a 64-bit settling run
`timescale 1ns/1ns
module delta_sigma_bitstream_output_tb;
   typedef struct {int lo; int hi;} dsb_note_t;
   logic                               REF_CLK;
   logic                               RESETN;
   logic signed [dsb_pkg::IN_W-1:0]    pos_in;
   logic signed [dsb_pkg::IN_W-1:0]    neg_in;
   logic                               mod_clk;
   logic                               data_out;
   logic                               done;
   logic                               last;
   logic                               changed;
   int                                 ones;
   int                                 n_errors;
   int                                 n_checks;
   int                                 seed;
   dsb_note_t                          notes[$];
   dsb_note_t                          nt;

   dsb_modulator dut_u (
      .REF_CLK    (REF_CLK),
      .RESETN     (RESETN),
      .MOD_CLK_IN (mod_clk),
      .POS_IN     (pos_in),
      .NEG_IN     (neg_in),
      .DATA_OUT   (data_out)
   );
   dsb_host_model host_u (
      .clk     (REF_CLK),
      .data_in (data_out),
      .mod_clk (mod_clk),
      .ones    (ones),
      .done    (done)
   );

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   task automatic err(input int got, input int exp);
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
   endtask

   task automatic stop_test;
      if (n_errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic span(input int p, input int n, input int lo, input int hi,
                       input int half);
      pos_in <= 16'(p);
      neg_in <= 16'(n);
      host_u.run_bits(64, half, 1'b0);
      notes.push_back('{lo, hi});
      host_u.run_bits(256, half, 1'b1);
   endtask

   // Ideal ones in 256 bits: 128 + diff / 250
   task automatic lin(input int p, input int n, input int half);
      int c;
      c = 128 + (p - n) / 250;
      span(p, n, c - 6, c + 6, half);
   endtask

   // ----------------------------------------------------------------------
   // Output watcher
   // ----------------------------------------------------------------------
   always @(posedge REF_CLK) begin
      if (done === 1'b1) begin
         nt = notes.pop_front();
         n_checks++;
         if (ones < nt.lo || ones > nt.hi) err(ones, nt.lo);
      end
      // A bit may move only while the bit clock is low, once per cycle
      if (RESETN === 1'b1 && data_out !== last) begin
         n_checks++;
         if (mod_clk !== 1'b0 || changed) err(data_out, last);
         changed = 1'b1;
      end
      if (mod_clk === 1'b1) changed = 1'b0;
      last = data_out;
   end

   // ----------------------------------------------------------------------
   // Clock, watchdog and sequence
   // ----------------------------------------------------------------------
   initial begin
      REF_CLK = 1'b0;
      forever #4 REF_CLK = ~REF_CLK;
   end

   initial begin
      #600000;
      n_errors++;
      stop_test();
   end

   initial begin
      RESETN = 1'b0;
      pos_in = '0;
      neg_in = '0;
      last = 1'b0;
      changed = 1'b0;
      n_errors = 0;
      n_checks = 0;
      seed = 32'hfeb1;
      repeat (5) @(posedge REF_CLK);
      RESETN <= 1'b1;
      repeat (4) @(posedge REF_CLK);
      lin(0, 0, 3);
      lin(25000, 0, 3);
      lin(0, 25000, 3);
      lin(-12000, -12000, 3);
      span(32000, 0, 256, 256, 3);
      span(-16000, 16000, 0, 0, 3);
      span(28000, 0, 222, 256, 3);
      span(0, 28000, 0, 34, 3);
      for (int i = 0; i < 4; i++) begin
         lin($random(seed) % 12000, $random(seed) % 12000, 3);
      end
      lin(10000, -5000, 12);
      stop_test();
   end
endmodule // delta_sigma_bitstream_output_tb
